// File: design/erri_pkg.sv
package erri_pkg;

	// ****************************************************************
	// Request conditioning
	// ****************************************************************
	localparam int   REQ_COUNT            = 2;
	localparam int   SYNC_STAGES_DEFAULT  = 2;
	localparam int   SYNC_STAGES_MIN      = 2;
	localparam int   REQ_INDEX_A          = 0;
	localparam int   REQ_INDEX_B          = 1;
	localparam logic TRIG_LEVEL           = 1'h0;
	localparam logic TRIG_EDGE            = 1'h1;
	localparam logic LINE_IDLE            = 1'h1;
	localparam logic PULLUP_RESET         = 1'h1;
	localparam logic REQUEST_RESET        = 1'h0;

	// ****************************************************************
	// Reset release and boot mode
	// ****************************************************************
	localparam int   RELEASE_CYCLES_DEFAULT = 16;
	localparam logic BOOT_INTERNAL          = 1'h0;
	localparam logic BOOT_EXTERNAL          = 1'h1;

	typedef enum logic [1:0]
	{
		RST_HELD,
		RST_COUNT,
		RST_DONE
	} erri_rst_state_t;

endpackage

// File: design/erri_req_cond.sv
`timescale 1ns/1ps

module erri_req_cond
#(
	parameter int SYNC_STAGES = erri_pkg::SYNC_STAGES_DEFAULT
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic reqLine_n,
	input  wire logic lowPower,
	input  wire logic trigMode,
	input  wire logic ack,
	input  wire logic pullupDisable,
	output logic      request_reg,
	output logic      pullupEn_reg
);

	import erri_pkg::*;

	// A shorter chain leaves metastability on the request path
	if (SYNC_STAGES < SYNC_STAGES_MIN)
	begin : gBadStages
		$error("erri_req_cond: SYNC_STAGES below minimum");
	end

	// ****************************************************************
	// Synchroniser and source select
	// ****************************************************************
	logic [SYNC_STAGES-1:0] syncChain_reg;
	logic                   sampled;
	logic                   prevLevel_reg;
	logic                   pending_reg;
	logic                   pending_next;
	logic                   fallSeen;

	// First stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (rst)
			syncChain_reg <= {SYNC_STAGES{LINE_IDLE}};
		else
			syncChain_reg <= {syncChain_reg[SYNC_STAGES-2:0], reqLine_n}; // see [RL2] [RL11]
	end

	// Low power bypasses the chain, but request_reg still needs a running clk
	assign sampled = lowPower ? reqLine_n : syncChain_reg[SYNC_STAGES-1]; // see [RL1] [RL2]

	always_ff @(posedge clk)
	begin
		if (rst)
			prevLevel_reg <= LINE_IDLE;
		else
			prevLevel_reg <= sampled;
	end

	// ****************************************************************
	// Trigger
	// ****************************************************************
	assign fallSeen = prevLevel_reg & ~sampled; // see [RL3]

	// A new edge beats an acknowledge in the same cycle
	// Level mode keeps no flag, so a mode switch fires no stale edge
	assign pending_next = (trigMode == TRIG_EDGE)
		&& (fallSeen || (pending_reg && !ack)); // see [RL10]

	always_ff @(posedge clk)
	begin
		if (rst)
			pending_reg <= REQUEST_RESET;
		else
			pending_reg <= pending_next; // see [RL10]
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			request_reg <= REQUEST_RESET;
		else if (trigMode == TRIG_EDGE)
			request_reg <= pending_next; // see [RL3]
		else
			request_reg <= ~sampled; // see [RL3]
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			pullupEn_reg <= PULLUP_RESET;
		else
			pullupEn_reg <= ~pullupDisable; // see [RL4]
	end

endmodule

// File: design/erri_top.sv
// Notes on behaviour
// [RL1] In Stop or Wait, request pins are taken without the synchroniser.
// [RL2] In other modes, request pins are synchronised to the clock first.
// [RL3] Each request is either level-sensitive or falling-edge triggered.
// [RL4] Pull-up disable bit switches off the request pin pull-ups.
// [RL5] While the reset pin is low, the chip stays in reset.
// [RL6] Boot source select pin is captured when the reset pin releases.
// [RL7] Internal reset ends on a clock edge after a fixed cycle count.
// [RL8] Board should drive the reset pin and test reset together.
// [RL9] High boot select boots off-chip unless flash is secured.
// [RL10] Edge-detected request stays pending until acknowledged.
// [RL11] Normal-mode synchroniser is at least two flip-flops deep.
`timescale 1ns/1ps

module erri_top
#(
	parameter int SYNC_STAGES    = erri_pkg::SYNC_STAGES_DEFAULT,
	parameter int RELEASE_CYCLES = erri_pkg::RELEASE_CYCLES_DEFAULT
)
(
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire logic                           resetPin_n,
	input  wire logic                           bootSourceSelect,
	input  wire logic                           flashSecured,
	input  wire logic                           lowPowerMode,
	input  wire logic                           extRequestA_n,
	input  wire logic                           extRequestB_n,
	input  wire logic [erri_pkg::REQ_COUNT-1:0] triggerMode,
	input  wire logic [erri_pkg::REQ_COUNT-1:0] requestAck,
	input  wire logic                           pullupDisable,
	output logic      [erri_pkg::REQ_COUNT-1:0] interruptRequest,
	output logic      [erri_pkg::REQ_COUNT-1:0] requestPullupEn,
	output logic                                internalReset,
	output logic                                bootExternal,
	output logic                                bootModeValid
);

	import erri_pkg::*;

	localparam int CNT_W = $clog2(RELEASE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RELEASE_CYCLES - 1);

	if (RELEASE_CYCLES < 1)
	begin : gBadCycles
		$error("erri_top: RELEASE_CYCLES must be at least one");
	end

	if (SYNC_STAGES < SYNC_STAGES_MIN)
	begin : gBadStages
		$error("erri_top: SYNC_STAGES below minimum");
	end

	// ****************************************************************
	// Request conditioning
	// ****************************************************************
	logic [REQ_COUNT-1:0] reqLine_n;

	assign reqLine_n[REQ_INDEX_A] = extRequestA_n;
	assign reqLine_n[REQ_INDEX_B] = extRequestB_n;

	genvar gi;
	generate
		for (gi = 0; gi < REQ_COUNT; gi++)
		begin : gReq
			erri_req_cond #(
				.SYNC_STAGES (SYNC_STAGES)
			) uCond (
				.clk           (clk),
				.rst           (rst),
				.reqLine_n     (reqLine_n[gi]),
				.lowPower      (lowPowerMode),
				.trigMode      (triggerMode[gi]),
				.ack           (requestAck[gi]),
				.pullupDisable (pullupDisable),
				.request_reg   (interruptRequest[gi]),
				.pullupEn_reg  (requestPullupEn[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// Reset sequencing
	// ****************************************************************
	erri_rst_state_t   state_reg;
	erri_rst_state_t   state_next;
	logic [CNT_W-1:0]  cnt_reg;
	logic              releaseEdge;

	// The pin is assumed clean; the Schmitt input does the filtering
	assign releaseEdge = (state_reg == RST_HELD) && resetPin_n;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			RST_HELD:
			begin
				if (resetPin_n)
					state_next = RST_COUNT;
			end
			RST_COUNT:
			begin
				if (!resetPin_n)
					state_next = RST_HELD; // see [RL5]
				else if (cnt_reg == CNT_LAST)
					state_next = RST_DONE; // see [RL7]
			end
			RST_DONE:
			begin
				if (!resetPin_n)
					state_next = RST_HELD; // see [RL5]
			end
			default:
				state_next = RST_HELD;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_reg <= RST_HELD;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clk)
	begin
		if (rst || state_reg != RST_COUNT)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + 1'h1; // see [RL7]
	end

	// Deasserts on a clock edge, never straight from the pin
	always_ff @(posedge clk)
	begin
		if (rst)
			internalReset <= 1'h1;
		else
			internalReset <= (state_next != RST_DONE); // see [RL5] [RL7]
	end

	// ****************************************************************
	// Boot mode latch
	// ****************************************************************
	// Captured only once per release, so later pin noise is harmless
	always_ff @(posedge clk)
	begin
		if (rst)
			bootExternal <= BOOT_INTERNAL;
		else if (releaseEdge)
			bootExternal <= (bootSourceSelect && !flashSecured)
				? BOOT_EXTERNAL : BOOT_INTERNAL; // see [RL6] [RL9]
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			bootModeValid <= 1'h0;
		else if (releaseEdge)
			bootModeValid <= 1'h1; // see [RL6]
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	AST_HOLD_RESET: assert property ( // see [RL5]
		@(posedge clk) disable iff (rst)
		!resetPin_n |=> internalReset ##1 (internalReset || resetPin_n))
		else $error("internal reset dropped while reset pin low");

	AST_RELEASE_COUNT: assert property ( // see [RL7]
		@(posedge clk) disable iff (rst)
		$fell(internalReset) |->
			$past(cnt_reg) == CNT_LAST && $past(resetPin_n))
		else $error("internal reset ended at wrong count");

	AST_RELEASE_START: assert property ( // see [RL7]
		@(posedge clk) disable iff (rst)
		releaseEdge ##1 resetPin_n |-> internalReset && cnt_reg == '0)
		else $error("release did not start counting from zero");

	AST_BOOT_LATCH: assert property ( // see [RL6]
		@(posedge clk) disable iff (rst)
		releaseEdge |=> bootModeValid &&
			bootExternal == ($past(bootSourceSelect) && !$past(flashSecured)))
		else $error("boot source not captured at release");

	AST_BOOT_STABLE: assert property ( // see [RL9]
		@(posedge clk) disable iff (rst)
		!releaseEdge |=> $stable(bootExternal))
		else $error("boot mode changed outside release");

	generate
		for (gi = 0; gi < REQ_COUNT; gi++)
		begin : gAst
			AST_PULLUP: assert property ( // see [RL4]
				@(posedge clk) disable iff (rst)
				##1 requestPullupEn[gi] == !$past(pullupDisable))
				else $error("pull-up enable does not follow disable bit");

			AST_SYNC_LEVEL: assert property ( // see [RL2] [RL11]
				@(posedge clk) disable iff (rst)
				(!lowPowerMode && triggerMode[gi] == TRIG_LEVEL)[*4] |->
					interruptRequest[gi] == !$past(reqLine_n[gi], 3))
				else $error("normal-mode level request not synchronised");

			AST_ASYNC_LEVEL: assert property ( // see [RL1]
				@(posedge clk) disable iff (rst)
				(lowPowerMode && triggerMode[gi] == TRIG_LEVEL)[*2] |->
					interruptRequest[gi] == !$past(reqLine_n[gi]))
				else $error("low-power request not taken directly");

			AST_EDGE_SET: assert property ( // see [RL3]
				@(posedge clk) disable iff (rst)
				(lowPowerMode && triggerMode[gi] == TRIG_EDGE)[*2] ##0
					$fell(reqLine_n[gi]) |=> interruptRequest[gi])
				else $error("falling edge did not raise request");

			AST_EDGE_HOLD: assert property ( // see [RL10]
				@(posedge clk) disable iff (rst)
				(triggerMode[gi] == TRIG_EDGE)[*2] ##0
					(interruptRequest[gi] && !requestAck[gi])
					|=> interruptRequest[gi])
				else $error("pending request lost without acknowledge");

			AST_EDGE_CLEAR: assert property ( // see [RL10]
				@(posedge clk) disable iff (rst)
				(lowPowerMode && triggerMode[gi] == TRIG_EDGE)[*2] ##0
					(requestAck[gi] && $stable(reqLine_n[gi]))
					|=> !interruptRequest[gi])
				else $error("acknowledge did not clear pending request");
		end
	endgenerate

endmodule

// File: tb/erri_partner.sv
`timescale 1ns/1ps

// ****************************************************************
// Request sources and board reset source
// ****************************************************************
module erri_partner
(
	input  wire logic [1:0] pullLow,
	input  wire logic [1:0] pullupEn,
	input  wire logic       boardReset,
	output logic      [1:0] reqLine_n,
	output logic            resetPin_n,
	output logic            testReset_n
);
	// A released line with no pull-up floats: show the inverse level
	always @(pullLow, pullupEn)
	begin
		for (int i = 0; i < 2; i++)
			reqLine_n[i] = pullLow[i] ? 1'h0 :
				(pullupEn[i] ? 1'h1 : ~reqLine_n[i]);
	end

	// Board reset drives both reset inputs together
	always_comb
	begin
		resetPin_n  = !boardReset;
		testReset_n = !boardReset;
	end
endmodule

// File: tb/erri_top_tb.sv
`timescale 1ns/1ps

module erri_top_tb;
	import erri_pkg::*;
	localparam int RC = 4;
	logic       clk;
	logic       rst;
	logic       bss;
	logic       sec;
	logic       lowPower;
	logic [1:0] trig;
	logic [1:0] ack;
	logic       pullDis;
	logic [1:0] pullLow;
	logic       boardReset;
	logic [1:0] reqLine_n;
	logic       resetPin_n;
	logic [1:0] irq;
	logic [1:0] pullEn;
	logic       intRst;
	logic       bootExt;
	logic       bootValid;
	int         n_fail;
	int         check_count;
	int         cycles;

	erri_partner erri_partner_i (.pullLow(pullLow), .pullupEn(pullEn),
		.boardReset(boardReset), .reqLine_n(reqLine_n),
		.resetPin_n(resetPin_n), .testReset_n());

	erri_top #(.RELEASE_CYCLES(RC)) erri_top_i (.clk(clk), .rst(rst),
		.resetPin_n(resetPin_n), .bootSourceSelect(bss),
		.flashSecured(sec), .lowPowerMode(lowPower),
		.extRequestA_n(reqLine_n[0]), .extRequestB_n(reqLine_n[1]),
		.triggerMode(trig), .requestAck(ack), .pullupDisable(pullDis),
		.interruptRequest(irq), .requestPullupEn(pullEn),
		.internalReset(intRst), .bootExternal(bootExt),
		.bootModeValid(bootValid));

	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %0t: got %b expected %b", $time, got, exp);
		end
	endtask

	task tally_and_finish();
		$display("Checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic pullup_check();
		@(posedge clk);
		pullDis <= 1'h1;
		#1 chk(bootValid, 1'h0);
		chk(intRst, 1'h1);
		@(posedge clk);
		#1 chk(pullEn, 2'h0);
		@(posedge clk);
		pullDis <= 1'h0;
		@(posedge clk);
		#1 chk(pullEn, 2'h3);
	endtask

	task automatic reset_release(input logic b, input logic s);
		@(posedge clk);
		boardReset <= 1'h1;
		bss <= b;
		sec <= s;
		@(posedge clk);
		#1 chk(intRst, 1'h1);
		@(posedge clk);
		boardReset <= 1'h0;
		// Boot pin moves after release: latched mode must not follow
		// Reset stands on the release edge and the RC-1 edges after it
		repeat (RC)
		begin
			@(posedge clk);
			bss <= !b;
			#1 chk(intRst, 1'h1);
		end
		@(posedge clk);
		#1 chk(intRst, 1'h0);
		chk(bootExt, b & !s);
		chk(bootValid, 1'h1);
	endtask

	task automatic req_level(input int idx, input logic lp);
		int d;
		d = lp ? 1 : 3;
		@(posedge clk);
		lowPower <= lp;
		trig[idx] <= TRIG_LEVEL;
		repeat (4) @(posedge clk);
		pullLow[idx] <= 1'h1;
		repeat (d - 1)
		begin
			@(posedge clk);
			#1 chk(irq[idx], 1'h0);
		end
		@(posedge clk);
		#1 chk(irq[idx], 1'h1);
		@(posedge clk);
		pullLow[idx] <= 1'h0;
		repeat (d) @(posedge clk);
		#1 chk(irq[idx], 1'h0);
	endtask

	task automatic req_edge(input int idx, input logic lp);
		@(posedge clk);
		lowPower <= lp;
		trig[idx] <= TRIG_EDGE;
		repeat (3) @(posedge clk);
		// Falls seen in level mode must not leave a request behind
		#1 chk(irq[idx], 1'h0);
		@(posedge clk);
		pullLow[idx] <= 1'h1;
		repeat (lp ? 1 : 3) @(posedge clk);
		#1 chk(irq[idx], 1'h1);
		@(posedge clk);
		pullLow[idx] <= 1'h0;
		repeat (4) @(posedge clk);
		#1 chk(irq[idx], 1'h1);
		@(posedge clk);
		ack[idx] <= 1'h1;
		@(posedge clk);
		ack[idx] <= 1'h0;
		#1 chk(irq[idx], 1'h0);
	endtask

	// A new fall sampled with an acknowledge keeps the request pending
	task automatic req_edge_race(input int idx);
		@(posedge clk);
		lowPower <= 1'h1;
		trig[idx] <= TRIG_EDGE;
		pullLow[idx] <= 1'h1;
		@(posedge clk);
		pullLow[idx] <= 1'h0;
		@(posedge clk);
		pullLow[idx] <= 1'h1;
		ack[idx] <= 1'h1;
		@(posedge clk);
		ack[idx] <= 1'h0;
		pullLow[idx] <= 1'h0;
		#1 chk(irq[idx], 1'h1);
		@(posedge clk);
		ack[idx] <= 1'h1;
		@(posedge clk);
		ack[idx] <= 1'h0;
		#1 chk(irq[idx], 1'h0);
	endtask

	// ****************************************************************
	// Clock, timeout and main sequence
	// ****************************************************************
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// Whole sequence needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	initial
	begin
		rst = 1'h1;
		bss = 1'h0;
		sec = 1'h0;
		lowPower = 1'h0;
		trig = 2'h0;
		ack = 2'h0;
		pullDis = 1'h0;
		pullLow = 2'h0;
		boardReset = 1'h1;
		n_fail = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		pullup_check();
		reset_release(1'h1, 1'h0);
		reset_release(1'h1, 1'h1);
		reset_release(1'h0, 1'h0);
		for (int i = 0; i < 4; i++)
			req_level(i % 2, 1'(i / 2));
		for (int i = 0; i < 4; i++)
			req_edge(i % 2, 1'(i / 2));
		req_edge_race(0);
		tally_and_finish();
	end
endmodule
